/* logic/npc_pkg.sv */
// Purpose: constants for the next-page and port configuration register bank
// Assumes: 5-bit management register address, 16-bit register words
// Notes:   shared by the register bank and its word register leaf
//
// Functional notes
// - transmit more-pages flag is writable, one means more pages follow; resets 0.
// - transmit message-format flag writable, resets 1, selects formatted or user code.
// - transmit toggle bit is read/write, resets 0, software sets it per page.
// - transmit eleven-bit code field is read/write and resets to value one.
// - receive more-pages bit shows partner has further pages; resets 0.
// - receive acknowledge bit shows partner received our code word; resets 0.
// - receive message-format bit is read-only, resets 0, qualifies partner code bits.
// - receive comply-acknowledge bit is read-only, resets 0, shows partner compliance.
// - receive toggle bit is read-only, resets 0, reflects partner toggle.
// - receive eleven-bit code field is read-only and resets to zero.
// - force-link-pass bit forces link passing; zero gives normal qualification.
// - transmit-disable bit turns the twisted-pair transmitter off; resets 0.
// - scrambler-bypass bit bypasses scrambler and descrambler in 100 Mbit mode.
// - jabber bit disables jabber correction in 10 Mbit mode; resets 0.
// - heartbeat bit enables heartbeat in 10 Mbit mode; resets 0.
// - decode 16,17,18,19,20,26,30; other addresses 21 to 31 are reserved.
// - new page loads base or next-page receive register, sets clear-on-read flag.
// - local next-page-able status bit reads one after reset.

package npc_pkg;
   localparam int unsigned ADDR_W = 5;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned CODE_W = 11;
   localparam int unsigned EXT_N  = 6;

   // register addresses
   localparam logic [4:0] ADDR_LP_BASE  = 5'h05;
   localparam logic [4:0] ADDR_AN_EXP   = 5'h06;
   localparam logic [4:0] ADDR_PG_TX    = 5'h07;
   localparam logic [4:0] ADDR_PG_RX    = 5'h08;
   localparam logic [4:0] ADDR_CFG      = 5'h10;
   localparam logic [4:0] ADDR_STAT2    = 5'h11;
   localparam logic [4:0] ADDR_INT_EN   = 5'h12;
   localparam logic [4:0] ADDR_STAT_CHG = 5'h13;
   localparam logic [4:0] ADDR_LED_CFG  = 5'h14;
   localparam logic [4:0] ADDR_DIG_CFG  = 5'h1a;
   localparam logic [4:0] ADDR_TX_CTRL  = 5'h1e;
   localparam logic [4:0] ADDR_PS_FIRST = 5'h10;

   // external select positions
   localparam int unsigned EXT_STAT2    = 0;
   localparam int unsigned EXT_INT_EN   = 1;
   localparam int unsigned EXT_STAT_CHG = 2;
   localparam int unsigned EXT_LED_CFG  = 3;
   localparam int unsigned EXT_DIG_CFG  = 4;
   localparam int unsigned EXT_TX_CTRL  = 5;

   // next-page word fields, shared by transmit and receive layouts
   localparam int unsigned PG_MORE_PAGES = 15;
   localparam int unsigned PG_ACK        = 14;
   localparam int unsigned PG_MSG_FORMAT = 13;
   localparam int unsigned PG_COMPLY_ACK = 12;
   localparam int unsigned PG_TOGGLE     = 11;

   // expansion status fields
   localparam int unsigned EXP_PG_ABLE = 2;
   localparam int unsigned EXP_PAGE_RX = 1;

   // configuration fields
   localparam int unsigned CFG_FORCE_LINK = 14;
   localparam int unsigned CFG_TX_DISABLE = 13;
   localparam int unsigned CFG_SCR_BYPASS = 12;
   localparam int unsigned CFG_JABBER_DIS = 10;
   localparam int unsigned CFG_HEARTBEAT  = 9;

   // reset values and write masks
   localparam logic [15:0] RST_PG_TX  = 16'h2001;
   localparam logic [15:0] MASK_PG_TX = 16'hbfff;
   localparam logic [15:0] RST_CFG    = 16'h0080;
   localparam logic [15:0] MASK_CFG   = 16'hffff;
   localparam logic [15:0] RST_RX     = 16'h0000;
   localparam logic [15:0] MASK_RX    = 16'hffff;
endpackage

/* logic/npc_word_reg.sv */
// Purpose: one 16-bit register word with load strobe and write mask
// Assumes: masked-off bits stay at zero
// Notes:   reset value and mask are parameters per instance

`timescale 1ns/1ps
`default_nettype none

module npc_word_reg
   import npc_pkg::*;
#(
   parameter logic [15:0] RESET = 16'h0000,
   parameter logic [15:0] MASK  = 16'hffff
) (
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   input  wire logic        load_i,
   input  wire logic [15:0] data_i,
   output logic      [15:0] q_o
);
   logic [15:0] word;
   logic [15:0] next_word;

   // take masked data on load
   always_comb begin
      next_word = word;
      if (load_i) begin
         next_word = data_i & MASK;
      end
   end

   // register the word
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         word <= RESET & MASK;
      end else begin
         word <= next_word;
      end
   end

   assign q_o = word;
endmodule

`default_nettype wire

/* logic/npc_regs.sv */
// Purpose: next-page transmit/receive registers, port configuration, decode
// Assumes: management port is one access per cycle, synchronous to clock_i
// Notes:   read data returns one cycle after the read strobe

`timescale 1ns/1ps
`default_nettype none

module npc_regs
   import npc_pkg::*;
(
   input  wire logic              clock_i,
   input  wire logic              rst_i,
   input  wire logic [ADDR_W-1:0] mgmt_addr_i,
   input  wire logic              mgmt_wr_i,
   input  wire logic              mgmt_rd_i,
   input  wire logic [15:0]       mgmt_wdata_i,
   output logic      [15:0]       mgmt_rdata_o,
   output logic                   mgmt_rvalid_o,
   output logic                   mgmt_reserved_o,
   input  wire logic              page_rx_i,
   input  wire logic              page_is_next_i,
   input  wire logic [15:0]       page_word_i,
   input  wire logic              speed_100_i,
   input  wire logic [15:0]       ext_rdata_i,
   output logic      [EXT_N-1:0]  ext_sel_o,
   output logic                   ext_wr_o,
   output logic                   ext_rd_o,
   output logic      [15:0]       ext_wdata_o,
   output logic      [15:0]       tx_code_word_o,
   output logic                   page_received_o,
   output logic                   force_link_pass_o,
   output logic                   tx_disable_o,
   output logic                   scrambler_bypass_o,
   output logic                   jabber_corr_disable_o,
   output logic                   heartbeat_test_enable_o
);
   logic [15:0]      pg_tx;
   logic [15:0]      pg_rx;
   logic [15:0]      lp_base;
   logic [15:0]      cfg;
   logic             wr_pg_tx;
   logic             wr_cfg;
   logic             rd_exp;
   logic             load_pg_rx;
   logic             load_base;
   logic [EXT_N-1:0] ext_hit;
   logic             is_reserved;
   logic [15:0]      exp_word;
   logic [15:0]      rd_mux;

   // address decode of the management access
   always_comb begin
      wr_pg_tx   = mgmt_wr_i && (mgmt_addr_i == ADDR_PG_TX);
      wr_cfg     = mgmt_wr_i && (mgmt_addr_i == ADDR_CFG);
      rd_exp     = mgmt_rd_i && (mgmt_addr_i == ADDR_AN_EXP);
      load_pg_rx = page_rx_i && page_is_next_i;
      load_base  = page_rx_i && !page_is_next_i;
      ext_hit    = '0;
      ext_hit[EXT_STAT2]    = (mgmt_addr_i == ADDR_STAT2);
      ext_hit[EXT_INT_EN]   = (mgmt_addr_i == ADDR_INT_EN);
      ext_hit[EXT_STAT_CHG] = (mgmt_addr_i == ADDR_STAT_CHG);
      ext_hit[EXT_LED_CFG]  = (mgmt_addr_i == ADDR_LED_CFG);
      ext_hit[EXT_DIG_CFG]  = (mgmt_addr_i == ADDR_DIG_CFG);
      ext_hit[EXT_TX_CTRL]  = (mgmt_addr_i == ADDR_TX_CTRL);
      is_reserved = (mgmt_addr_i >= ADDR_PS_FIRST) && (mgmt_addr_i != ADDR_CFG)
                    && !(|ext_hit);
   end

   // next-page transmit word, sent as the local code word
   npc_word_reg #(
      .RESET (RST_PG_TX),
      .MASK  (MASK_PG_TX)
   ) u_pg_tx (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .load_i  (wr_pg_tx),
      .data_i  (mgmt_wdata_i),
      .q_o     (pg_tx)
   );

   // partner next-page word, loaded only by the negotiation
   npc_word_reg #(
      .RESET (RST_RX),
      .MASK  (MASK_RX)
   ) u_pg_rx (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .load_i  (load_pg_rx),
      .data_i  (page_word_i),
      .q_o     (pg_rx)
   );

   // partner base page word
   npc_word_reg #(
      .RESET (RST_RX),
      .MASK  (MASK_RX)
   ) u_lp_base (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .load_i  (load_base),
      .data_i  (page_word_i),
      .q_o     (lp_base)
   );

   // port configuration word, reserved bits stored as written
   npc_word_reg #(
      .RESET (RST_CFG),
      .MASK  (MASK_CFG)
   ) u_cfg (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .load_i  (wr_cfg),
      .data_i  (mgmt_wdata_i),
      .q_o     (cfg)
   );

   assign tx_code_word_o = pg_tx;

   // page received flag, a new page wins over the clearing read
   logic next_page_received;
   always_comb begin
      next_page_received = page_received_o;
      if (page_rx_i) begin
         next_page_received = 1'b1;
      end else if (rd_exp) begin
         next_page_received = 1'b0;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         page_received_o <= 1'b0;
      end else begin
         page_received_o <= next_page_received;
      end
   end

   // read multiplexer
   always_comb begin
      exp_word = '0;
      exp_word[EXP_PG_ABLE] = 1'b1;
      exp_word[EXP_PAGE_RX] = page_received_o;
      case (mgmt_addr_i)
         ADDR_LP_BASE: rd_mux = lp_base;
         ADDR_AN_EXP:  rd_mux = exp_word;
         ADDR_PG_TX:   rd_mux = pg_tx;
         ADDR_PG_RX:   rd_mux = pg_rx;
         ADDR_CFG:     rd_mux = cfg;
         default:      rd_mux = (|ext_hit) ? ext_rdata_i : 16'h0000;
      endcase
   end

   // management answer and external strobes
   logic [15:0]      next_rdata;
   logic             next_rvalid;
   logic             next_reserved;
   logic [EXT_N-1:0] next_ext_sel;
   logic             next_ext_wr;
   logic             next_ext_rd;
   logic [15:0]      next_ext_wdata;
   always_comb begin
      next_rdata     = mgmt_rd_i ? rd_mux : mgmt_rdata_o;
      next_rvalid    = mgmt_rd_i;
      next_reserved  = (mgmt_rd_i || mgmt_wr_i) && is_reserved;
      next_ext_sel   = (mgmt_rd_i || mgmt_wr_i) ? ext_hit : '0;
      next_ext_wr    = mgmt_wr_i && (|ext_hit);
      next_ext_rd    = mgmt_rd_i && (|ext_hit);
      next_ext_wdata = next_ext_wr ? mgmt_wdata_i : ext_wdata_o;
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         mgmt_rdata_o    <= 16'h0000;
         mgmt_rvalid_o   <= 1'b0;
         mgmt_reserved_o <= 1'b0;
         ext_sel_o       <= '0;
         ext_wr_o        <= 1'b0;
         ext_rd_o        <= 1'b0;
         ext_wdata_o     <= 16'h0000;
      end else begin
         mgmt_rdata_o    <= next_rdata;
         mgmt_rvalid_o   <= next_rvalid;
         mgmt_reserved_o <= next_reserved;
         ext_sel_o       <= next_ext_sel;
         ext_wr_o        <= next_ext_wr;
         ext_rd_o        <= next_ext_rd;
         ext_wdata_o     <= next_ext_wdata;
      end
   end

   // line controls from configuration, scrambler, jabber and heartbeat gated by speed mode
   logic next_force;
   logic next_txdis;
   logic next_scr;
   logic next_jab;
   logic next_hb;
   always_comb begin
      next_force = cfg[CFG_FORCE_LINK];
      next_txdis = cfg[CFG_TX_DISABLE];
      next_scr   = cfg[CFG_SCR_BYPASS] && speed_100_i;
      next_jab   = cfg[CFG_JABBER_DIS] && !speed_100_i;
      next_hb    = cfg[CFG_HEARTBEAT] && !speed_100_i;
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         force_link_pass_o       <= 1'b0;
         tx_disable_o            <= 1'b0;
         scrambler_bypass_o      <= 1'b0;
         jabber_corr_disable_o   <= 1'b0;
         heartbeat_test_enable_o <= 1'b0;
      end else begin
         force_link_pass_o       <= next_force;
         tx_disable_o            <= next_txdis;
         scrambler_bypass_o      <= next_scr;
         jabber_corr_disable_o   <= next_jab;
         heartbeat_test_enable_o <= next_hb;
      end
   end

   // checks on the register bank
   property p_tx_write;
      @(posedge clock_i) disable iff (rst_i)
      wr_pg_tx |=> (tx_code_word_o == ($past(mgmt_wdata_i) & MASK_PG_TX));
   endproperty
   a_tx_write: assert property (p_tx_write) else $error("transmit word not loaded");

   property p_tx_hold;
      @(posedge clock_i) disable iff (rst_i)
      !wr_pg_tx |=> $stable(tx_code_word_o);
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("transmit word changed without write");

   property p_tx_reserved;
      @(posedge clock_i) disable iff (rst_i)
      !tx_code_word_o[PG_ACK];
   endproperty
   a_tx_reserved: assert property (p_tx_reserved) else $error("reserved transmit bit set");

   property p_rx_load;
      @(posedge clock_i) disable iff (rst_i)
      load_pg_rx ##1 (mgmt_rd_i && mgmt_addr_i == ADDR_PG_RX && !page_rx_i)
      |=> mgmt_rdata_o == $past(page_word_i, 2);
   endproperty
   a_rx_load: assert property (p_rx_load) else $error("next page receive not loaded");

   property p_base_keeps_rx;
      @(posedge clock_i) disable iff (rst_i)
      load_base |=> $stable(pg_rx);
   endproperty
   a_base_keeps_rx: assert property (p_base_keeps_rx) else $error("base page overwrote next page");

   property p_page_flag_set;
      @(posedge clock_i) disable iff (rst_i)
      page_rx_i |=> page_received_o;
   endproperty
   a_page_flag_set: assert property (p_page_flag_set) else $error("page received flag not set");

   property p_page_flag_clear;
      @(posedge clock_i) disable iff (rst_i)
      (rd_exp && !page_rx_i) |=> !page_received_o && mgmt_rdata_o[EXP_PG_ABLE]
                                 && (mgmt_rdata_o[EXP_PAGE_RX] == $past(page_received_o));
   endproperty
   a_page_flag_clear: assert property (p_page_flag_clear) else $error("page flag clear or able bit");

   property p_force;
      @(posedge clock_i) disable iff (rst_i)
      wr_cfg ##1 !wr_cfg |=> force_link_pass_o == $past(mgmt_wdata_i[CFG_FORCE_LINK], 2);
   endproperty
   a_force: assert property (p_force) else $error("force link output wrong");

   property p_txdis;
      @(posedge clock_i) disable iff (rst_i)
      wr_cfg ##1 !wr_cfg |=> tx_disable_o == $past(mgmt_wdata_i[CFG_TX_DISABLE], 2);
   endproperty
   a_txdis: assert property (p_txdis) else $error("transmit disable output wrong");

   property p_speed_gate;
      @(posedge clock_i) disable iff (rst_i)
      (scrambler_bypass_o |-> $past(speed_100_i))
      and ((jabber_corr_disable_o || heartbeat_test_enable_o) |-> !$past(speed_100_i));
   endproperty
   a_speed_gate: assert property (p_speed_gate) else $error("mode control outside its speed");

   property p_jab_hb;
      @(posedge clock_i) disable iff (rst_i)
      !speed_100_i |=> (jabber_corr_disable_o == $past(cfg[CFG_JABBER_DIS]))
                    && (heartbeat_test_enable_o == $past(cfg[CFG_HEARTBEAT]));
   endproperty
   a_jab_hb: assert property (p_jab_hb) else $error("10 Mbit controls wrong");

   property p_reserved_addr;
      @(posedge clock_i) disable iff (rst_i)
      (mgmt_rd_i && is_reserved) |=> mgmt_rvalid_o && mgmt_reserved_o && (mgmt_rdata_o == 16'h0000)
                                     && (ext_sel_o == '0);
   endproperty
   a_reserved_addr: assert property (p_reserved_addr) else $error("reserved address answered");

   property p_ext_sel;
      @(posedge clock_i) disable iff (rst_i)
      (mgmt_wr_i && mgmt_addr_i == ADDR_TX_CTRL) |=> ext_wr_o && ext_sel_o[EXT_TX_CTRL] && $onehot(ext_sel_o);
   endproperty
   a_ext_sel: assert property (p_ext_sel) else $error("external select wrong");

   c_next_page: cover property (@(posedge clock_i) disable iff (rst_i) load_pg_rx ##1 rd_exp);
   c_flag_race: cover property (@(posedge clock_i) disable iff (rst_i) page_rx_i && rd_exp);
   c_tx_last:   cover property (@(posedge clock_i) disable iff (rst_i)
                                wr_pg_tx && !mgmt_wdata_i[PG_MORE_PAGES]);
   c_reserved:  cover property (@(posedge clock_i) disable iff (rst_i) mgmt_reserved_o);
endmodule

`default_nettype wire

/* test/npc_mgmt_model.sv */
// Purpose: station manager model issuing single register reads and writes
// Assumes: strobes change 1 ns after the rising edge, one access per call
// Notes:   idle address and data lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module npc_mgmt_model
   import npc_pkg::*;
(
   input  wire logic              clock_i,
   input  wire logic [15:0]       rdata_i,
   input  wire logic              rvalid_i,
   output logic      [ADDR_W-1:0] addr_o,
   output logic                   wr_o,
   output logic                   rd_o,
   output logic      [15:0]       wdata_o
);
   // idle bus at time zero
   initial begin
      addr_o = '0;
      wr_o = 1'b0;
      rd_o = 1'b0;
      wdata_o = '0;
   end

   // one write strobe, config bits 15 and 11 sent as zero
   task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [15:0] d);
      @(posedge clock_i);
      #1;
      addr_o = a;
      wdata_o = (a == ADDR_CFG) ? (d & 16'h77ff) : d;
      wr_o = 1'b1;
      @(posedge clock_i);
      #1;
      wr_o = 1'b0;
      addr_o = ~addr_o;
      wdata_o = ~wdata_o;
   endtask

   // one read strobe, bounded wait for the valid pulse
   task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [15:0] d, output logic ok);
      int n;
      ok = 1'b0;
      d = '0;
      @(posedge clock_i);
      #1;
      addr_o = a;
      rd_o = 1'b1;
      @(posedge clock_i);
      #1;
      rd_o = 1'b0;
      addr_o = ~addr_o;
      for (n = 0; n < 4 && !ok; n++) begin
         if (rvalid_i === 1'b1) begin
            ok = 1'b1;
            d = (a == ADDR_CFG) ? (rdata_i & 16'h77ff) : rdata_i;
         end else begin
            @(posedge clock_i);
            #1;
         end
      end
   endtask
endmodule
`default_nettype wire

/* test/next_page_and_port_config_regs_test.sv */
// Purpose: self-checking bench for the next-page and port configuration bank
// Assumes: 40 MHz clock, inputs driven 1 ns after the rising edge
// Notes:   ext bank answers with its address in the low bits
`timescale 1ns/1ps
`default_nettype none
module next_page_and_port_config_regs_test
   import npc_pkg::*;
;
   logic              clock_i;
   logic              rst_i;
   logic [ADDR_W-1:0] addr;
   logic              wr;
   logic              rd;
   logic [15:0]       wdata;
   logic [15:0]       rdata;
   logic              rvalid;
   logic              reserved;
   logic              page_rx;
   logic              page_is_next;
   logic [15:0]       page_word;
   logic              speed_100;
   logic [15:0]       ext_rdata;
   logic [EXT_N-1:0]  ext_sel;
   logic              ext_wr;
   logic              ext_rd;
   logic [15:0]       ext_wdata;
   logic [15:0]       tx_word;
   logic              page_received;
   wire  [4:0]        outs;
   int                error_cnt;
   int                check_count;

   npc_regs uut (.clock_i(clock_i), .rst_i(rst_i), .mgmt_addr_i(addr), .mgmt_wr_i(wr), .mgmt_rd_i(rd),
      .mgmt_wdata_i(wdata), .mgmt_rdata_o(rdata), .mgmt_rvalid_o(rvalid), .mgmt_reserved_o(reserved),
      .page_rx_i(page_rx), .page_is_next_i(page_is_next), .page_word_i(page_word), .speed_100_i(speed_100),
      .ext_rdata_i(ext_rdata), .ext_sel_o(ext_sel), .ext_wr_o(ext_wr), .ext_rd_o(ext_rd),
      .ext_wdata_o(ext_wdata), .tx_code_word_o(tx_word), .page_received_o(page_received),
      .force_link_pass_o(outs[4]), .tx_disable_o(outs[3]), .scrambler_bypass_o(outs[2]),
      .jabber_corr_disable_o(outs[1]), .heartbeat_test_enable_o(outs[0]));

   npc_mgmt_model mdl (.clock_i(clock_i), .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(addr), .wr_o(wr),
      .rd_o(rd), .wdata_o(wdata));

   // free-running clock
   initial begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end

   // verdict and end of run
   task automatic stop_test();
      if (error_cnt == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // compare one value
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // read and compare, a lost answer ends the run
   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
      logic [15:0] d;
      logic        ok;
      mdl.read_reg(a, d, ok);
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("[ERR] %0t no read answer", $time);
         stop_test();
      end else begin
         check(d, exp, "read data");
      end
   endtask

   // one received page pulse
   task automatic send_page(input logic nxt, input logic [15:0] w);
      @(posedge clock_i);
      #1;
      page_rx = 1'b1;
      page_is_next = nxt;
      page_word = w;
      @(posedge clock_i);
      #1;
      page_rx = 1'b0;
      page_word = ~w;
   endtask

   // decode map of the extension bank
   function automatic int ext_idx(input int a);
      case (a)
         17: return 0;
         18: return 1;
         19: return 2;
         20: return 3;
         26: return 4;
         30: return 5;
         default: return -1;
      endcase
   endfunction

   // reset values of every register except the partner base page, and of the config outputs
   task automatic t_reset();
      rd_chk(ADDR_PG_TX, 16'h2001);
      check(tx_word, 16'h2001, "tx word");
      rd_chk(ADDR_PG_RX, 16'h0000);
      rd_chk(ADDR_CFG, 16'h0080);
      rd_chk(ADDR_AN_EXP, 16'h0004);
      check({11'h0, outs}, 16'h0000, "cfg outputs");
   endtask

   // transmit page fields writable, reserved bit reads zero
   task automatic t_np_tx();
      mdl.write_reg(ADDR_PG_TX, 16'hffff);
      rd_chk(ADDR_PG_TX, 16'hbfff);
      check(tx_word, 16'hbfff, "tx word");
      mdl.write_reg(ADDR_PG_TX, 16'h1000);
      rd_chk(ADDR_PG_TX, 16'h1000);
      check(tx_word, 16'h1000, "tx word");
   endtask

   // next and base pages load, flag clears on read
   task automatic t_page();
      send_page(1'b1, 16'hd5a3);
      check({15'h0, page_received}, 16'h0001, "page flag");
      send_page(1'b1, 16'h2a5c);
      mdl.write_reg(ADDR_PG_RX, 16'hffff);
      rd_chk(ADDR_PG_RX, 16'h2a5c);
      rd_chk(ADDR_AN_EXP, 16'h0006);
      rd_chk(ADDR_AN_EXP, 16'h0004);
      check({15'h0, page_received}, 16'h0000, "page flag");
      send_page(1'b0, 16'h41e1);
      rd_chk(ADDR_LP_BASE, 16'h41e1);
      rd_chk(ADDR_PG_RX, 16'h2a5c);
   endtask

   // page and clearing read in one cycle, then a read right after a load
   task automatic t_race();
      rd_chk(ADDR_AN_EXP, 16'h0006);
      fork
         send_page(1'b1, 16'h1357);
         rd_chk(ADDR_AN_EXP, 16'h0004);
      join
      check({15'h0, page_received}, 16'h0001, "set wins");
      fork
         send_page(1'b1, 16'h8642);
         begin
            @(posedge clock_i);
            rd_chk(ADDR_PG_RX, 16'h8642);
         end
      join
   endtask

   // reset in mid-run restores every reset value that t_reset checks
   task automatic t_rst_again();
      mdl.write_reg(ADDR_PG_TX, 16'h0a55);
      mdl.write_reg(ADDR_CFG, 16'h4000);
      @(posedge clock_i);
      #1;
      rst_i = 1'b1;
      repeat (2) @(posedge clock_i);
      #1;
      rst_i = 1'b0;
      t_reset();
   endtask

   // each config bit alone, at both speeds
   task automatic t_cfg();
      int cb[5];
      int i;
      cb = '{14, 13, 12, 10, 9};
      for (i = 0; i < 5; i++) begin
         speed_100 = (i < 3);
         mdl.write_reg(ADDR_CFG, 16'h0001 << cb[i]);
         @(posedge clock_i);
         #1;
         check({11'h0, outs}, 16'h0010 >> i, "cfg outputs");
         speed_100 = !(i < 3);
         @(posedge clock_i);
         #1;
         check({11'h0, outs}, (i < 2) ? 16'h0010 >> i : 16'h0000, "speed gate");
      end
      mdl.write_reg(ADDR_CFG, 16'h0000);
      @(posedge clock_i);
      #1;
      check({11'h0, outs}, 16'h0000, "cfg cleared");
   endtask

   // address decode over the product-specific range
   task automatic t_decode();
      int a;
      int k;
      for (a = 16; a < 32; a++) begin
         k = ext_idx(a);
         ext_rdata = 16'hc300 | 16'(a);
         rd_chk(5'(a), (k >= 0) ? 16'hc300 | 16'(a) : (a == 16) ? 16'h0080 : 16'h0000);
         check({8'h0, ext_rd, reserved, ext_sel}, (k >= 0) ? 16'h0080 | (16'h1 << k) :
               (a == 16) ? 16'h0000 : 16'h0040, "decode");
      end
      mdl.write_reg(ADDR_TX_CTRL, 16'h5a5a);
      check({ext_wr, reserved, ext_sel}, 8'ha0, "ext write");
      check(ext_wdata, 16'h5a5a, "ext data");
      mdl.write_reg(5'h15, 16'h1234);
      check({ext_wr, reserved, ext_sel}, 8'h40, "reserved write");
   endtask

   // main sequence
   initial begin
      error_cnt = 0;
      check_count = 0;
      rst_i = 1'b1;
      page_rx = 1'b0;
      page_is_next = 1'b0;
      page_word = '0;
      speed_100 = 1'b1;
      ext_rdata = '0;
      repeat (16) @(posedge clock_i);
      #1;
      rst_i = 1'b0;
      t_reset();
      t_decode();
      t_np_tx();
      t_page();
      t_race();
      t_cfg();
      t_rst_again();
      stop_test();
   end
endmodule
`default_nettype wire
